// ---- src/accu_x_motion_command_decoder.sv ----
`timescale 1ns/100ps
module accu_x_motion_command_decoder #(
    parameter logic [7:0] ROTATE_RIGHT_CMD_CODE = 8'h01,
    parameter logic [7:0] ROTATE_LEFT_CMD_CODE = 8'h02,
    parameter logic [7:0] MOTOR_HALT_CMD_CODE = 8'h03
) (
    // Clock, reset, enable
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    // Command byte stream
    input wire logic [7:0] i_rx_byte,
    input wire logic i_rx_valid,
    output logic o_rx_ready,
    input wire logic [7:0] i_module_addr,
    // Working registers and axis state
    input wire logic [31:0] i_accu,
    input wire logic [31:0] i_xreg,
    input wire logic [95:0] i_act_pos,
    input wire logic [2:0] i_pos_reached,
    // Stored coordinate lookup
    output logic o_stored_point_move_type_rd,
    output logic [1:0] o_stored_point_move_type_axis,
    output logic [31:0] o_stored_point_move_type_idx,
    input wire logic [31:0] i_stored_point_move_type_data,
    // Motion controller write port
    output logic o_mc_wr,
    output logic [1:0] o_mc_axis,
    output logic o_mc_vel_mode,
    output logic o_mc_dir_up,
    output logic [7:0] o_mc_param,
    output logic [31:0] o_mc_data,
    output logic [2:0] o_pos_busy,
    output logic o_pos_abort,
    // Reply
    output logic o_reply_valid,
    output logic [7:0] o_reply_status,
    output logic [7:0] o_reply_instr
);

    // ****************************************
    // Types and helpers
    // ****************************************
    typedef enum logic [2:0] {
        S_IDLE = 3'b001,
        S_STORED_POINT_MOVE_TYPE = 3'b010,
        S_REPLY = 3'b100
    } state_e;

    function automatic logic axis_in_range(input logic [31:0] a);
        axis_in_range = (a <= {24'h0, motion_cmd_pkg::AXIS_MAX});
    endfunction

    function automatic logic [2:0] axis_mask(input logic [1:0] a);
        axis_mask = 3'b001 << a;
    endfunction

    // ****************************************
    // Frame assembly
    // ****************************************
    logic frame_valid, sum_ok;
    logic [7:0] f_addr, f_instr, f_type, f_motor;
    logic [31:0] f_value;
    logic rx_ready_r;

    frame_collector u_frame (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_ce(i_ce),
        .i_rx_byte(i_rx_byte),
        .i_rx_valid(i_rx_valid),
        .i_rx_ready(rx_ready_r),
        .o_frame_valid(frame_valid),
        .o_addr(f_addr),
        .o_instr(f_instr),
        .o_type(f_type),
        .o_motor(f_motor),
        .o_value(f_value),
        .o_sum_ok(sum_ok)
    );

    // ****************************************
    // Decode
    // ****************************************
    wire take = frame_valid && (f_addr == i_module_addr);
    wire is_rl = (f_instr == motion_cmd_pkg::INSTR_ROTATE_LEFT_ACCU);
    wire is_rr = (f_instr == motion_cmd_pkg::INSTR_ROTATE_RIGHT_ACCU);
    wire is_rlx = (f_instr == motion_cmd_pkg::INSTR_ROTATE_LEFT_ACCU_XSEL);
    wire is_rrx = (f_instr == motion_cmd_pkg::INSTR_ROTATE_RIGHT_ACCU_XSEL);
    wire is_mvx = (f_instr == motion_cmd_pkg::INSTR_MOVE_POS_ACCU_XSEL);
    wire is_rot = is_rl || is_rr || is_rlx || is_rrx;
    wire use_x = is_rlx || is_rrx || is_mvx;
    wire ours = is_rot || is_mvx;
    wire foreign_stop = (f_instr == MOTOR_HALT_CMD_CODE) || (f_instr == ROTATE_LEFT_CMD_CODE)
        || (f_instr == ROTATE_RIGHT_CMD_CODE);
    // Only the low two bits address an axis once the range check has passed
    wire [1:0] axis = use_x ? i_xreg[1:0] : f_motor[1:0];
    wire axis_ok = use_x ? axis_in_range(i_xreg) : axis_in_range({24'h0, f_motor});
    wire type_ok = (f_type <= motion_cmd_pkg::STORED_POINT_MOVE_TYPE);
    wire dir_up = is_rr || is_rrx;
    // Wraps at 32 bits; the host keeps the distance in range
    wire [31:0] act_pos = i_act_pos[32*axis +: 32];
    wire [31:0] rel_target = act_pos + i_accu;

    // ****************************************
    // State
    // ****************************************
    state_e state_r, state_nxt;
    logic [2:0] busy_r, busy_nxt;
    logic mc_wr_r, mc_wr_nxt, mc_vel_r, mc_vel_nxt, mc_dir_r, mc_dir_nxt;
    logic [1:0] mc_axis_r, mc_axis_nxt;
    logic [7:0] mc_param_r, mc_param_nxt;
    logic [31:0] mc_data_r, mc_data_nxt;
    logic stored_point_move_type_rd_r, stored_point_move_type_rd_nxt;
    logic abort_r, abort_nxt;
    logic rep_valid_r, rep_valid_nxt;
    logic [7:0] status_r, status_nxt, rinstr_r, rinstr_nxt;
    logic [31:0] stored_point_move_type_idx_r, stored_point_move_type_idx_nxt;
    logic [2:0] set_mask, clr_mask;

    always_comb begin
        state_nxt = state_r;
        mc_wr_nxt = 1'b0;
        mc_vel_nxt = mc_vel_r;
        mc_dir_nxt = mc_dir_r;
        mc_axis_nxt = mc_axis_r;
        mc_param_nxt = mc_param_r;
        mc_data_nxt = mc_data_r;
        stored_point_move_type_rd_nxt = 1'b0;
        stored_point_move_type_idx_nxt = stored_point_move_type_idx_r;
        abort_nxt = 1'b0;
        rep_valid_nxt = 1'b0;
        status_nxt = status_r;
        rinstr_nxt = rinstr_r;
        set_mask = 3'b000;
        clr_mask = 3'b000;
        case (state_r)
            S_IDLE: begin
                if (take) begin
                    rinstr_nxt = f_instr;
                    if (!sum_ok) begin
                        status_nxt = motion_cmd_pkg::STATUS_BAD_SUM;
                        state_nxt = S_REPLY;
                    end else if (foreign_stop) begin
                        // Other decoders execute these; here only the positioning move is dropped
                        if (axis_in_range({24'h0, f_motor})) begin
                            clr_mask = axis_mask(f_motor[1:0]);
                            abort_nxt = |(busy_r & axis_mask(f_motor[1:0]));
                        end
                    end else if (ours) begin
                        state_nxt = S_REPLY;
                        status_nxt = motion_cmd_pkg::STATUS_OK;
                        if (!axis_ok) begin
                            status_nxt = motion_cmd_pkg::STATUS_BAD_VALUE;
                        end else if (is_mvx && !type_ok) begin
                            status_nxt = motion_cmd_pkg::STATUS_BAD_TYPE;
                        end else if (is_rot) begin
                            mc_wr_nxt = 1'b1;
                            mc_axis_nxt = axis;
                            mc_vel_nxt = 1'b1;
                            mc_dir_nxt = dir_up;
                            mc_param_nxt = motion_cmd_pkg::PARAM_TARGET_VEL;
                            mc_data_nxt = i_accu;
                            clr_mask = axis_mask(axis);
                            abort_nxt = |(busy_r & axis_mask(axis));
                        end else begin
                            mc_axis_nxt = axis;
                            mc_vel_nxt = 1'b0;
                            mc_dir_nxt = 1'b0;
                            mc_param_nxt = motion_cmd_pkg::PARAM_TARGET_POS;
                            if (f_type == motion_cmd_pkg::STORED_POINT_MOVE_TYPE) begin
                                stored_point_move_type_rd_nxt = 1'b1;
                                stored_point_move_type_idx_nxt = i_accu;
                                state_nxt = S_STORED_POINT_MOVE_TYPE;
                            end else begin
                                mc_wr_nxt = 1'b1;
                                set_mask = axis_mask(axis);
                                if (f_type == motion_cmd_pkg::RELATIVE_MOVE_TYPE) begin
                                    mc_data_nxt = rel_target;
                                end else begin
                                    mc_data_nxt = i_accu;
                                end
                            end
                        end
                    end
                end
            end
            S_STORED_POINT_MOVE_TYPE: begin
                mc_wr_nxt = 1'b1;
                mc_data_nxt = i_stored_point_move_type_data;
                set_mask = axis_mask(mc_axis_r);
                state_nxt = S_REPLY;
            end
            S_REPLY: begin
                // Reply right after setup; motion runs on without the decoder
                rep_valid_nxt = 1'b1;
                state_nxt = S_IDLE;
            end
            default: begin
                state_nxt = S_IDLE;
            end
        endcase
        // A move that ends in the same cycle it is re-armed stays busy
        busy_nxt = (busy_r & ~i_pos_reached & ~clr_mask) | set_mask;
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            state_r <= S_IDLE;
            busy_r <= 3'b000;
            mc_wr_r <= 1'b0;
            mc_vel_r <= 1'b0;
            mc_dir_r <= 1'b0;
            mc_axis_r <= 2'h0;
            mc_param_r <= motion_cmd_pkg::RST_BYTE;
            mc_data_r <= motion_cmd_pkg::RST_WORD;
            stored_point_move_type_rd_r <= 1'b0;
            stored_point_move_type_idx_r <= motion_cmd_pkg::RST_WORD;
            abort_r <= 1'b0;
            rep_valid_r <= 1'b0;
            status_r <= motion_cmd_pkg::RST_BYTE;
            rinstr_r <= motion_cmd_pkg::RST_BYTE;
            rx_ready_r <= 1'b0;
        end else if (i_ce) begin
            state_r <= state_nxt;
            busy_r <= busy_nxt;
            mc_wr_r <= mc_wr_nxt;
            mc_vel_r <= mc_vel_nxt;
            mc_dir_r <= mc_dir_nxt;
            mc_axis_r <= mc_axis_nxt;
            mc_param_r <= mc_param_nxt;
            mc_data_r <= mc_data_nxt;
            stored_point_move_type_rd_r <= stored_point_move_type_rd_nxt;
            stored_point_move_type_idx_r <= stored_point_move_type_idx_nxt;
            abort_r <= abort_nxt;
            rep_valid_r <= rep_valid_nxt;
            status_r <= status_nxt;
            rinstr_r <= rinstr_nxt;
            // Bytes are held off while a frame is still being executed
            rx_ready_r <= (state_nxt == S_IDLE) && !take;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign o_rx_ready = rx_ready_r;
    assign o_stored_point_move_type_rd = stored_point_move_type_rd_r;
    assign o_stored_point_move_type_axis = mc_axis_r;
    assign o_stored_point_move_type_idx = stored_point_move_type_idx_r;
    assign o_mc_wr = mc_wr_r;
    assign o_mc_axis = mc_axis_r;
    assign o_mc_vel_mode = mc_vel_r;
    assign o_mc_dir_up = mc_dir_r;
    assign o_mc_param = mc_param_r;
    assign o_mc_data = mc_data_r;
    assign o_pos_busy = busy_r;
    assign o_pos_abort = abort_r;
    assign o_reply_valid = rep_valid_r;
    assign o_reply_status = status_r;
    assign o_reply_instr = rinstr_r;

endmodule

// ---- src/motion_cmd_pkg.sv ----
package motion_cmd_pkg;

    // ****************************************
    // Frame layout
    // ****************************************
    localparam int FRAME_BYTES = 9;
    localparam logic [3:0] IDX_ADDR = 4'h0;
    localparam logic [3:0] IDX_INSTR = 4'h1;
    localparam logic [3:0] IDX_TYPE = 4'h2;
    localparam logic [3:0] IDX_MOTOR = 4'h3;
    localparam logic [3:0] IDX_VAL_MSB = 4'h4;
    localparam logic [3:0] IDX_VAL_LSB = 4'h7;
    localparam logic [3:0] IDX_SUM = 4'h8;

    // ****************************************
    // Instruction codes
    // ****************************************
    localparam logic [7:0] INSTR_MOVE_POS_ACCU_XSEL = 8'h2f;
    localparam logic [7:0] INSTR_ROTATE_LEFT_ACCU = 8'h32;
    localparam logic [7:0] INSTR_ROTATE_RIGHT_ACCU = 8'h33;
    localparam logic [7:0] INSTR_ROTATE_LEFT_ACCU_XSEL = 8'h34;
    localparam logic [7:0] INSTR_ROTATE_RIGHT_ACCU_XSEL = 8'h35;

    // ****************************************
    // Move types and axes
    // ****************************************
    localparam logic [7:0] ABSOLUTE_MOVE_TYPE = 8'h00;
    localparam logic [7:0] RELATIVE_MOVE_TYPE = 8'h01;
    localparam logic [7:0] STORED_POINT_MOVE_TYPE = 8'h02;
    localparam int AXES = 3;
    localparam logic [7:0] AXIS_MAX = 8'h02;

    // ****************************************
    // Axis parameter numbers
    // ****************************************
    localparam logic [7:0] PARAM_TARGET_POS = 8'h00;
    localparam logic [7:0] PARAM_TARGET_VEL = 8'h02;

    // ****************************************
    // Reply status codes
    // ****************************************
    localparam logic [7:0] STATUS_OK = 8'h64;
    localparam logic [7:0] STATUS_BAD_SUM = 8'h01;
    localparam logic [7:0] STATUS_BAD_TYPE = 8'h03;
    localparam logic [7:0] STATUS_BAD_VALUE = 8'h04;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;

endpackage

// ---- src/frame_collector.sv ----
`timescale 1ns/100ps
module frame_collector (
    // Clock, reset, enable
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    // Byte stream
    input wire logic [7:0] i_rx_byte,
    input wire logic i_rx_valid,
    input wire logic i_rx_ready,
    // Assembled frame
    output logic o_frame_valid,
    output logic [7:0] o_addr,
    output logic [7:0] o_instr,
    output logic [7:0] o_type,
    output logic [7:0] o_motor,
    output logic [31:0] o_value,
    output logic o_sum_ok
);

    // ****************************************
    // Byte counter and running sum
    // ****************************************
    logic [3:0] cnt_r;
    logic [7:0] sum_r;
    logic [7:0] addr_r, instr_r, type_r, motor_r;
    logic [31:0] value_r;
    logic valid_r, ok_r;

    wire take = i_rx_valid && i_rx_ready;
    wire last = (cnt_r == motion_cmd_pkg::IDX_SUM);

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            cnt_r <= 4'h0;
            sum_r <= motion_cmd_pkg::RST_BYTE;
            addr_r <= motion_cmd_pkg::RST_BYTE;
            instr_r <= motion_cmd_pkg::RST_BYTE;
            type_r <= motion_cmd_pkg::RST_BYTE;
            motor_r <= motion_cmd_pkg::RST_BYTE;
            value_r <= motion_cmd_pkg::RST_WORD;
            valid_r <= 1'b0;
            ok_r <= 1'b0;
        end else if (i_ce) begin
            valid_r <= take && last;
            if (take) begin
                cnt_r <= last ? 4'h0 : cnt_r + 4'h1;
                sum_r <= last ? motion_cmd_pkg::RST_BYTE : sum_r + i_rx_byte;
                // Fields in arrival order, value high byte first
                if (cnt_r == motion_cmd_pkg::IDX_ADDR) addr_r <= i_rx_byte;
                if (cnt_r == motion_cmd_pkg::IDX_INSTR) instr_r <= i_rx_byte;
                if (cnt_r == motion_cmd_pkg::IDX_TYPE) type_r <= i_rx_byte;
                if (cnt_r == motion_cmd_pkg::IDX_MOTOR) motor_r <= i_rx_byte;
                if (cnt_r >= motion_cmd_pkg::IDX_VAL_MSB && cnt_r <= motion_cmd_pkg::IDX_VAL_LSB) begin
                    value_r <= {value_r[23:0], i_rx_byte};
                end
                if (last) ok_r <= (sum_r == i_rx_byte);
            end
        end
    end

    assign o_frame_valid = valid_r;
    assign o_addr = addr_r;
    assign o_instr = instr_r;
    assign o_type = type_r;
    assign o_motor = motor_r;
    assign o_value = value_r;
    assign o_sum_ok = ok_r;

endmodule

// ---- sim/motion_cmd_checker.sv ----
`timescale 1ns/100ps
module motion_cmd_checker (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // Stored point lookup
    input wire logic o_stored_point_move_type_rd,
    input wire logic [1:0] o_stored_point_move_type_axis,
    input wire logic [31:0] i_stored_point_move_type_data,
    // Motion controller and reply
    input wire logic o_rx_ready,
    input wire logic o_mc_wr,
    input wire logic [1:0] o_mc_axis,
    input wire logic o_mc_vel_mode,
    input wire logic o_mc_dir_up,
    input wire logic [7:0] o_mc_param,
    input wire logic [31:0] o_mc_data,
    input wire logic [2:0] o_pos_busy,
    input wire logic o_pos_abort,
    input wire logic o_reply_valid,
    input wire logic [7:0] o_reply_status,
    input wire logic [7:0] o_reply_instr
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);

    a_rot_param: assert property (o_mc_wr && o_mc_vel_mode |->
        o_mc_param == motion_cmd_pkg::PARAM_TARGET_VEL && !o_pos_busy[o_mc_axis]) else $error("rotate write bad");
    a_move_param: assert property (o_mc_wr && !o_mc_vel_mode |->
        o_mc_param == motion_cmd_pkg::PARAM_TARGET_POS && o_pos_busy[o_mc_axis]) else $error("move write bad");
    a_axis_range: assert property (o_mc_wr |-> o_mc_axis <= 2'h2) else $error("axis out of range");
    a_write_reply: assert property (o_mc_wr |=>
        o_reply_valid && o_reply_status == motion_cmd_pkg::STATUS_OK) else $error("no ok reply after write");
    a_ready_back: assert property (o_mc_wr |->
        !o_rx_ready ##1 o_rx_ready) else $error("ready not back after reply");
    a_left_dir: assert property (o_reply_valid && o_reply_status == 8'h64 &&
        o_reply_instr inside {8'h32, 8'h34} |-> o_mc_vel_mode && !o_mc_dir_up) else $error("left dir bad");
    a_right_dir: assert property (o_reply_valid && o_reply_status == 8'h64 &&
        o_reply_instr inside {8'h33, 8'h35} |-> o_mc_vel_mode && o_mc_dir_up) else $error("right dir bad");
    a_stored_point_move_type_load: assert property (o_stored_point_move_type_rd |=> o_mc_wr && o_mc_data == $past(i_stored_point_move_type_data) &&
        o_mc_axis == $past(o_stored_point_move_type_axis)) else $error("stored point not loaded");
    a_abort_drop: assert property (o_pos_abort |->
        $countones(o_pos_busy) < $countones($past(o_pos_busy))) else $error("abort left busy");
endmodule

bind accu_x_motion_command_decoder motion_cmd_checker chk_u (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
    .o_stored_point_move_type_rd(o_stored_point_move_type_rd), .o_stored_point_move_type_axis(o_stored_point_move_type_axis), .i_stored_point_move_type_data(i_stored_point_move_type_data), .o_rx_ready(o_rx_ready),
    .o_mc_wr(o_mc_wr), .o_mc_axis(o_mc_axis), .o_mc_vel_mode(o_mc_vel_mode), .o_mc_dir_up(o_mc_dir_up),
    .o_mc_param(o_mc_param), .o_mc_data(o_mc_data), .o_pos_busy(o_pos_busy), .o_pos_abort(o_pos_abort),
    .o_reply_valid(o_reply_valid), .o_reply_status(o_reply_status), .o_reply_instr(o_reply_instr));

// ---- sim/host_frame_model.sv ----
`timescale 1ns/100ps
module host_frame_model (
    // Clock
    input wire logic i_ref_clk,
    // Byte stream
    input wire logic i_rx_ready,
    output logic [7:0] o_rx_byte,
    output logic o_rx_valid
);
    logic [7:0] frame [9];

    initial begin
        o_rx_byte = 8'h00;
        o_rx_valid = 1'b0;
    end

    // Idle line shows the inverse of the last byte so stale data never looks valid
    task automatic send(input logic [7:0] adr, ins, typ, mot, input logic [31:0] val, input logic bad, input int gap);
        int n;
        frame = '{adr, ins, typ, mot, val[31:24], val[23:16], val[15:8], val[7:0], 8'h00};
        for (int k = 0; k < 8; k++) begin
            frame[8] = frame[8] + frame[k];
        end
        frame[8] = frame[8] ^ {7'h0, bad};
        for (int k = 0; k < 9; k++) begin
            o_rx_valid <= 1'b1;
            o_rx_byte <= frame[k];
            n = 0;
            do begin
                @(posedge i_ref_clk);
                n++;
            end while (i_rx_ready !== 1'b1 && n < 40);
            if (gap > 0 && k < 8) begin
                o_rx_valid <= 1'b0;
                o_rx_byte <= ~frame[k];
                repeat (gap) @(posedge i_ref_clk);
            end
        end
        o_rx_valid <= 1'b0;
        o_rx_byte <= ~frame[8];
    endtask
endmodule

// ---- sim/accu_x_motion_command_decoder_tb_top.sv ----
`timescale 1ns/100ps
module accu_x_motion_command_decoder_tb_top;
    // ****************************************
    // Wiring and monitors
    // ****************************************
    logic i_ref_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_ce = 1'b1;
    logic [7:0] rx_byte, o_mc_param, o_reply_status, o_reply_instr;
    logic rx_valid, o_rx_ready, o_stored_point_move_type_rd, o_mc_wr, o_mc_vel_mode, o_mc_dir_up, o_pos_abort, o_reply_valid;
    logic [31:0] accu = 32'h0, xreg = 32'h0, stored_point_move_type = 32'h0, o_stored_point_move_type_idx, o_mc_data;
    logic [95:0] act_pos = 96'h0;
    logic [2:0] reached = 3'h0, o_pos_busy;
    logic [1:0] o_stored_point_move_type_axis, o_mc_axis;
    int fail_count = 0, total_checks = 0, cycles = 0, wr_cnt = 0, rep_cnt = 0, abort_cnt = 0, crd_cnt = 0;
    int w0, r0, a0, c0;

    always #12.5 i_ref_clk = ~i_ref_clk;

    accu_x_motion_command_decoder dut_u (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_ce(i_ce), .i_rx_byte(rx_byte),
        .i_rx_valid(rx_valid), .o_rx_ready(o_rx_ready), .i_module_addr(8'h01), .i_accu(accu), .i_xreg(xreg),
        .i_act_pos(act_pos), .i_pos_reached(reached), .o_stored_point_move_type_rd(o_stored_point_move_type_rd), .o_stored_point_move_type_axis(o_stored_point_move_type_axis),
        .o_stored_point_move_type_idx(o_stored_point_move_type_idx), .i_stored_point_move_type_data(stored_point_move_type), .o_mc_wr(o_mc_wr), .o_mc_axis(o_mc_axis),
        .o_mc_vel_mode(o_mc_vel_mode), .o_mc_dir_up(o_mc_dir_up), .o_mc_param(o_mc_param), .o_mc_data(o_mc_data),
        .o_pos_busy(o_pos_busy), .o_pos_abort(o_pos_abort), .o_reply_valid(o_reply_valid),
        .o_reply_status(o_reply_status), .o_reply_instr(o_reply_instr));
    host_frame_model host_u (.i_ref_clk(i_ref_clk), .i_rx_ready(o_rx_ready), .o_rx_byte(rx_byte),
        .o_rx_valid(rx_valid));

    // Pulses are counted here so a missed or doubled pulse shows as a count error
    always @(posedge i_ref_clk) begin
        cycles++;
        wr_cnt += (o_mc_wr === 1'b1);
        rep_cnt += (o_reply_valid === 1'b1);
        abort_cnt += (o_pos_abort === 1'b1);
        crd_cnt += (o_stored_point_move_type_rd === 1'b1);
        if (cycles == 4000) begin
            fail_count++;
            final_report();
        end
    end

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Commands that draw no reply fall out of the bounded wait
    task automatic cmd(input logic [7:0] adr, ins, typ, mot, input logic [31:0] val, input logic bad, input int gap);
        int n;
        w0 = wr_cnt;
        r0 = rep_cnt;
        a0 = abort_cnt;
        c0 = crd_cnt;
        host_u.send(adr, ins, typ, mot, val, bad, gap);
        n = 0;
        while (rep_cnt == r0 && n < 12) begin
            @(posedge i_ref_clk);
            n++;
        end
        @(posedge i_ref_clk);
    endtask

    task automatic final_report;
        if (fail_count == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_rotate;
        logic [7:0] code;
        for (int c = 0; c < 4; c++) begin
            for (int a = 0; a < 3; a++) begin
                code = 8'h32 + 8'(c);
                accu <= 32'h8000_0f00 + 32'(a);
                xreg <= (c < 2) ? 32'h7 : 32'(a);
                cmd(8'h01, code, 8'h5a, (c < 2) ? 8'(a) : 8'hff, 32'hdead_beef, 1'b0, 0);
                check(wr_cnt - w0, 1);
                check(o_mc_axis, a);
                check(o_mc_vel_mode, 1);
                check(o_mc_dir_up, code[0]);
                check(o_mc_param, 2);
                check(o_mc_data, 32'h8000_0f00 + 32'(a));
                check(o_reply_status, 100);
                check(o_reply_instr, code);
            end
        end
    endtask

    task automatic t_move;
        accu <= 32'h0001_2345;
        xreg <= 32'h2;
        cmd(8'h01, 8'h2f, 8'h00, 8'hff, 32'h0, 1'b0, 0);
        check(o_mc_data, 32'h0001_2345);
        check(o_mc_param, 0);
        check(o_pos_busy, 3'h4);
        check(o_reply_status, 100);
        accu <= 32'h0000_0020;
        xreg <= 32'h0;
        act_pos <= {64'h0, 32'hffff_fff0};
        cmd(8'h01, 8'h2f, 8'h01, 8'h00, 32'h0, 1'b0, 0);
        check(o_mc_data, 32'h0000_0010);
        check(o_pos_busy, 3'h5);
        // Enable low must freeze busy even while the axis reports reached
        i_ce <= 1'b0;
        reached <= 3'h4;
        repeat (2) @(posedge i_ref_clk);
        check(o_pos_busy, 3'h5);
        i_ce <= 1'b1;
        @(posedge i_ref_clk);
        reached <= 3'h0;
        @(posedge i_ref_clk);
        check(o_pos_busy, 3'h1);
        cmd(8'h01, 8'h32, 8'h00, 8'h00, 32'h0, 1'b0, 0);
        check(abort_cnt - a0, 1);
        check(o_pos_busy, 3'h0);
        xreg <= 32'h1;
        cmd(8'h01, 8'h2f, 8'h00, 8'h00, 32'h0, 1'b0, 0);
        cmd(8'h01, 8'h03, 8'h00, 8'h01, 32'h0, 1'b0, 0);
        check(abort_cnt - a0, 1);
        check(o_pos_busy, 3'h0);
    endtask

    task automatic t_stored;
        stored_point_move_type <= 32'h7654_3210;
        accu <= 32'h0000_0005;
        xreg <= 32'h1;
        cmd(8'h01, 8'h2f, 8'h02, 8'h00, 32'h0, 1'b0, 2);
        check(crd_cnt - c0, 1);
        check(o_stored_point_move_type_idx, 5);
        check(o_mc_data, 32'h7654_3210);
        check(o_mc_axis, 1);
        check(o_pos_busy, 3'h2);
        check(o_reply_status, 100);
    endtask

    // Refused frames: bad sum, axis 3 by motor field and by X, bad move type, unknown code, foreign address
    task automatic t_errors;
        logic [7:0] adr [7] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h02};
        logic [7:0] ins [7] = '{8'h32, 8'h32, 8'h34, 8'h2f, 8'h2f, 8'h60, 8'h32};
        logic [7:0] typ [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'h00, 8'h00};
        logic [7:0] mot [7] = '{8'h00, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        logic [7:0] xr [7] = '{8'h00, 8'h00, 8'h03, 8'h03, 8'h00, 8'h00, 8'h00};
        logic [7:0] st [7] = '{8'h01, 8'h04, 8'h04, 8'h04, 8'h03, 8'h00, 8'h00};
        for (int k = 0; k < 7; k++) begin
            xreg <= {24'h0, xr[k]};
            cmd(adr[k], ins[k], typ[k], mot[k], 32'h0, k == 0, 0);
            check(wr_cnt - w0, 0);
            check(rep_cnt - r0, st[k] != 8'h00);
            if (st[k] != 8'h00) check(o_reply_status, st[k]);
        end
    endtask

    initial begin
        repeat (2) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        t_rotate();
        t_move();
        t_stored();
        t_errors();
        final_report();
    end
endmodule
